// file: ncp_defs.svh
// Constants for the nibble command port: select code, byte framing,
// command register indices, descriptor store size and timing counts.
// Assumes a 25 MHz core clock; included by its bare name.
//
// Overview of operation
// - Port selected only by select code 100
// - Commands use data lines 7..0 only
// - Top bit set means address byte
// - Bit six: zero write, one read
// - Low six bits give register address
// - Data bytes carry upper nibble, then lower
// - New address drops pending address and nibble
// - Further bytes reuse address as nibble pairs
// - Ready drops per byte, rises when able
// - Lower nibble completes byte into register
// - Read data ready asserts interrupt low
// - Normal interrupts held during pending read
// - Five hundred byte descriptor store at 0x30
// - Full descriptor: release, parse, reconnect, enumerate
// - Chirp control 0x02 forces full speed
// - Length six selects built-in default descriptor
// - Unindexed access through 0x3A, 0x3B, 0x3C
// - Shares strobes and selects, no packet pin
`ifndef NCP_DEFS_SVH
`define NCP_DEFS_SVH

`define NCP_SEL_CMD 3'h4
`define NCP_ADDR_BIT 7
`define NCP_RW_BIT 6
`define NCP_REG_DESC 6'h30
`define NCP_REG_UIDX_LO 6'h3A
`define NCP_REG_UIDX_HI 6'h3B
`define NCP_REG_UIDX_VAL 6'h3C
`define NCP_CHIRP_ADDR 16'hE6FB
`define NCP_CHIRP_FS_BIT 1
`define NCP_CHIRP_RESET 8'h00
`define NCP_DESC_BYTES 500
`define NCP_DEFAULT_LEN 16'h0006
`define NCP_IRQ_ENUM_BIT 5
`define NCP_CLK_NS 40
`define NCP_BUSY_NS 80
`define NCP_BUSY_CYC ((`NCP_BUSY_NS + `NCP_CLK_NS - 1) / `NCP_CLK_NS)
`define NCP_PARSE_US 100
`define NCP_CONNECT_US 1000

`endif

// file: ncp_master.sv
// External bus master model driving the command port byte by byte.
// Assumes the bench calls its tasks; signals change just after clk edges.
`timescale 1ns/1ps
`default_nettype none
module ncp_master (
    // Clock and device replies
    input wire logic clk,
    input wire logic ready,
    input wire logic int_n,
    input wire logic [7:0] rd_data,
    input wire logic rd_oe,
    // Bus drives
    output logic [2:0] sel_lines,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic oe_n,
    output logic [7:0] data
);
    int waited;
    // Idle bus at time zero, command port selected
    initial begin
        sel_lines = 3'h4;
        cs_n = 1'h0;
        rd_n = 1'h1;
        wr_n = 1'h1;
        oe_n = 1'h1;
        data = 8'h00;
    end
    // Change select code and chip select; only the bench asks for wrong ones
    task automatic set_sel(input logic [2:0] s, input logic c);
        @(posedge clk);
        sel_lines <= s;
        cs_n <= c;
    endtask : set_sel
    // One byte on the low lines, once ready is seen high or after 100 cycles of waiting
    task automatic send(input logic [7:0] b);
        waited = 0;
        @(posedge clk);
        while (!ready && waited < 100) begin
            waited++;
            @(posedge clk);
        end
        wr_n <= 1'h0;
        data <= b;
        @(posedge clk);
        wr_n <= 1'h1;
        data <= ~b; // Released lines do not keep the last value
    endtask : send
    // Value as upper nibble byte, then lower nibble byte
    task automatic pair(input logic [7:0] v);
        send({4'h0, v[7:4]});
        send({4'h0, v[3:0]});
    endtask : pair
    // Full write: address byte then one nibble pair
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        send({2'h2, a});
        pair(v);
    endtask : wr
    // Wait for the interrupt, enable the bus, take the byte, strobe it away
    task automatic fetch(output logic [7:0] v);
        waited = 0;
        while (int_n && waited < 200) begin
            waited++;
            @(posedge clk);
        end
        oe_n <= 1'h0;
        repeat (2) @(posedge clk);
        v = rd_oe ? rd_data : ~rd_data;
        rd_n <= 1'h0;
        @(posedge clk);
        rd_n <= 1'h1;
        oe_n <= 1'h1;
        repeat (3) @(posedge clk);
    endtask : fetch
endmodule : ncp_master
`default_nettype wire

// file: ncp_pkg.sv
// Types for the nibble command port.
// Assumes nothing beyond a SystemVerilog compiler.
package ncp_pkg;
    // Command byte sequencer
    typedef enum logic [3:0] {
        NCP_IDLE = 4'h1,
        NCP_HI = 4'h2,
        NCP_LO = 4'h4,
        NCP_RD = 4'h8
    } ncp_cmd_state_type;

    // Enumeration sequencer after a descriptor load
    typedef enum logic [3:0] {
        NCP_EN_IDLE = 4'h1,
        NCP_EN_PARSE = 4'h2,
        NCP_EN_CONN = 4'h4,
        NCP_EN_DONE = 4'h8
    } ncp_enum_state_type;

    // Phases of the descriptor stream
    typedef enum logic [3:0] {
        NCP_DS_LEN_LO = 4'h1,
        NCP_DS_LEN_HI = 4'h2,
        NCP_DS_BODY = 4'h4,
        NCP_DS_FULL = 4'h8
    } ncp_desc_phase_type;
endpackage : ncp_pkg

// file: ncp_props.sv
// Checker for the nibble command port, watching ncp_top ports only.
// Assumes ce is held high while the checked traffic runs.
`timescale 1ns/1ps
`default_nettype none
module ncp_props #(
    parameter int PARSE_CYC = 4,
    parameter int CONNECT_CYC = 4
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Slave interface from the master
    input wire logic [2:0] endpoint_select_lines,
    input wire logic cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_pin_n,
    input wire logic [7:0] shared_data_bus_in,
    // Device outputs
    input wire logic shared_data_bus_oe,
    input wire logic ready,
    input wire logic int_n,
    input wire logic pullup_en,
    input wire logic full_speed_only,
    input wire logic [7:0] interface_setup
);
    logic sel;
    logic take;
    logic c_wait;
    logic [15:0] low_cnt_q;
    // Port selected, byte taken, interrupt left alone
    assign sel = endpoint_select_lines == 3'h4 && !cs_n;
    assign take = sel && ce && !write_strobe_n && ready;
    assign c_wait = !int_n && read_strobe_n && write_strobe_n;
    // Pull-up release length; a counter keeps long waits out of repetitions
    always_ff @(posedge clk) begin
        if (rst || pullup_en) begin
            low_cnt_q <= 16'h0000;
        end else begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence busy_s;
        !ready [*2] ##1 ready;
    endsequence
    sequence rd_take_s;
        take && shared_data_bus_in[7:6] == 2'h3;
    endsequence
    a_take_ready: assert property (take |=> busy_s)
        else $error("ready did not pace a taken byte");
    a_ready_rise: assert property ($rose(ready) && !$past(rst) |-> $past(take, 3))
        else $error("ready rose with no byte taken");
    a_oe_sel: assert property (shared_data_bus_oe && !$past(rst) |-> $past(sel && !output_enable_pin_n))
        else $error("data bus driven while not enabled");
    a_read_irq: assert property (rd_take_s |-> ##[2:3] !int_n)
        else $error("read data not signalled");
    a_int_hold: assert property (c_wait [*3] |=> !int_n)
        else $error("interrupt left before read strobe");
    a_setup_upd: assert property ($changed(interface_setup) && !$past(rst)
        |-> $past(take) || $past(take, 2) || $past(take, 3))
        else $error("register changed without a byte");
    a_fs_upd: assert property ($changed(full_speed_only) && !$past(rst)
        |-> $past(take) || $past(take, 2) || $past(take, 3))
        else $error("chirp control changed without a byte");
    a_parse_time: assert property ($rose(pullup_en) && !$past(rst) |-> low_cnt_q == PARSE_CYC)
        else $error("pull-up release length wrong");
endmodule : ncp_props
bind ncp_top ncp_props #(.PARSE_CYC(PARSE_CYC), .CONNECT_CYC(CONNECT_CYC)) ncp_props_inst (
    .clk(clk), .rst(rst), .ce(ce), .endpoint_select_lines(endpoint_select_lines),
    .cs_n(cs_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .output_enable_pin_n(output_enable_pin_n), .shared_data_bus_in(shared_data_bus_in),
    .shared_data_bus_oe(shared_data_bus_oe), .ready(ready), .int_n(int_n),
    .pullup_en(pullup_en), .full_speed_only(full_speed_only),
    .interface_setup(interface_setup)
);
`default_nettype wire

// file: ncp_top.sv
// Nibble command port: decodes command bytes from the shared parallel
// slave interface, holds the command register file and descriptor store.
// Assumes strobes are synchronous to clk and sampled as clock qualifiers.
`timescale 1ns/1ps
`default_nettype none
`include "ncp_defs.svh"

module ncp_top #(
    parameter int PARSE_CYC = `NCP_PARSE_US * 1000 / `NCP_CLK_NS,
    parameter int CONNECT_CYC = `NCP_CONNECT_US * 1000 / `NCP_CLK_NS
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Shared slave interface controls, strobes active low
    input wire logic [2:0] endpoint_select_lines,
    input wire logic cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_pin_n,
    // Low data lines of the shared data bus
    input wire logic [7:0] shared_data_bus_in,
    output logic [7:0] shared_data_bus_out,
    output logic shared_data_bus_oe,
    // Pacing and interrupt
    output logic ready,
    output logic int_n,
    // Normal interrupt sources, one-cycle pulses
    input wire logic [5:0] irq_src,
    // Device side effects
    output logic pullup_en,
    output logic full_speed_only,
    output logic default_desc,
    output logic [7:0] interface_setup,
    // Descriptor store read port for the parser
    input wire logic [8:0] desc_rd_addr,
    output logic [7:0] desc_rd_data
);
    localparam logic [1:0] BUSY_CYC = 2'(`NCP_BUSY_CYC);

    ncp_pkg::ncp_cmd_state_type state_q;
    ncp_pkg::ncp_enum_state_type en_q;
    ncp_pkg::ncp_desc_phase_type ds_q;
    logic [5:0] addr_q;
    logic [3:0] nib_q;
    logic [1:0] busy_q;
    logic [7:0] regs_q [0:63];
    logic [7:0] desc_ram [0:`NCP_DESC_BYTES-1];
    logic [15:0] len_q;
    logic [15:0] idx_q;
    logic [15:0] uidx_q;
    logic [7:0] chirp_q;
    logic [7:0] rd_data_q;
    logic rd_valid_q;
    logic [5:0] pend_q;
    logic [15:0] tmr_q;
    logic sel;
    logic take;
    logic rd_take;
    logic commit;
    logic [7:0] cbyte;
    logic start_enum;
    logic enum_done;
    logic status_rd;

    // Byte taken only when selected, chip selected, strobed and ready
    assign sel = (endpoint_select_lines == `NCP_SEL_CMD) && !cs_n;
    assign take = ce && sel && !write_strobe_n && ready;
    assign rd_take = ce && sel && !read_strobe_n;
    // Completed byte from the two nibbles
    assign commit = take && !shared_data_bus_in[`NCP_ADDR_BIT] && state_q == ncp_pkg::NCP_LO;
    assign cbyte = {nib_q, shared_data_bus_in[3:0]};
    assign status_rd = rd_take && state_q != ncp_pkg::NCP_RD;

    // Register value as seen by a read request
    function automatic logic [7:0] reg_view(input logic [5:0] a);
        if (a == `NCP_REG_DESC) begin
            reg_view = 8'h00;
        end else if (a == `NCP_REG_UIDX_VAL) begin
            reg_view = (uidx_q == `NCP_CHIRP_ADDR) ? chirp_q : 8'h00;
        end else begin
            reg_view = regs_q[a];
        end
    endfunction : reg_view

    // Command byte sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ncp_pkg::NCP_IDLE;
            addr_q <= 6'h00;
            nib_q <= 4'h0;
        end else if (take) begin
            if (shared_data_bus_in[`NCP_ADDR_BIT]) begin
                addr_q <= shared_data_bus_in[5:0];
                // Fresh address discards any half-received byte
                if (shared_data_bus_in[`NCP_RW_BIT]) begin
                    state_q <= ncp_pkg::NCP_RD;
                end else begin
                    state_q <= ncp_pkg::NCP_HI;
                end
            end else begin
                case (state_q)
                    ncp_pkg::NCP_HI: begin
                        nib_q <= shared_data_bus_in[3:0];
                        state_q <= ncp_pkg::NCP_LO;
                    end
                    // Same address stays open for further byte pairs
                    ncp_pkg::NCP_LO: state_q <= ncp_pkg::NCP_HI;
                    // Data with no open write is dropped
                    ncp_pkg::NCP_IDLE: state_q <= ncp_pkg::NCP_IDLE;
                    ncp_pkg::NCP_RD: state_q <= ncp_pkg::NCP_RD;
                    default: state_q <= ncp_pkg::NCP_IDLE;
                endcase
            end
        end else if (ce && rd_take && state_q == ncp_pkg::NCP_RD && rd_valid_q) begin
            state_q <= ncp_pkg::NCP_IDLE;
        end
    end

    // Ready pacing; low for a few cycles after each byte
    always_ff @(posedge clk) begin
        if (rst) begin
            ready <= 1'b1;
            busy_q <= 2'h0;
        end else if (ce) begin
            if (take) begin
                ready <= 1'b0;
                busy_q <= BUSY_CYC;
            end else if (busy_q > 2'h1) begin
                busy_q <= busy_q - 2'h1;
            end else begin
                busy_q <= 2'h0;
                ready <= 1'b1;
            end
        end
    end

    // Indexed register file; only the descriptor slot is kept out, unindexed slots are stored here too
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 64; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (commit && addr_q != `NCP_REG_DESC) begin
            regs_q[addr_q] <= cbyte;
        end
    end

    // Unindexed access: address low, address high, then value
    always_ff @(posedge clk) begin
        if (rst) begin
            uidx_q <= 16'h0000;
            chirp_q <= `NCP_CHIRP_RESET;
        end else if (commit) begin
            if (addr_q == `NCP_REG_UIDX_LO) begin
                uidx_q[7:0] <= cbyte;
            end else if (addr_q == `NCP_REG_UIDX_HI) begin
                uidx_q[15:8] <= cbyte;
            end else if (addr_q == `NCP_REG_UIDX_VAL && uidx_q == `NCP_CHIRP_ADDR) begin
                chirp_q <= cbyte;
            end
        end
    end

    // Descriptor stream: length low, length high, then body bytes
    assign start_enum = commit && addr_q == `NCP_REG_DESC &&
        ((ds_q == ncp_pkg::NCP_DS_LEN_HI && {cbyte, len_q[7:0]} == 16'h0000) ||
         (ds_q == ncp_pkg::NCP_DS_BODY && idx_q + 16'h0001 == len_q));
    always_ff @(posedge clk) begin
        if (rst) begin
            ds_q <= ncp_pkg::NCP_DS_LEN_LO;
            len_q <= 16'h0000;
            idx_q <= 16'h0000;
        end else if (commit && addr_q == `NCP_REG_DESC) begin
            case (ds_q)
                ncp_pkg::NCP_DS_LEN_LO: begin
                    len_q[7:0] <= cbyte;
                    ds_q <= ncp_pkg::NCP_DS_LEN_HI;
                end
                ncp_pkg::NCP_DS_LEN_HI: begin
                    len_q[15:8] <= cbyte;
                    ds_q <= start_enum ? ncp_pkg::NCP_DS_FULL : ncp_pkg::NCP_DS_BODY;
                end
                ncp_pkg::NCP_DS_BODY: begin
                    idx_q <= idx_q + 16'h0001;
                    if (start_enum) begin
                        ds_q <= ncp_pkg::NCP_DS_FULL;
                    end
                end
                ncp_pkg::NCP_DS_FULL: ds_q <= ncp_pkg::NCP_DS_FULL;
                default: ds_q <= ncp_pkg::NCP_DS_LEN_LO;
            endcase
        end
    end

    // Store body bytes; overlong loads keep only what fits
    always_ff @(posedge clk) begin
        if (commit && addr_q == `NCP_REG_DESC && ds_q == ncp_pkg::NCP_DS_BODY &&
            idx_q < 16'(`NCP_DESC_BYTES)) begin
            desc_ram[idx_q[8:0]] <= cbyte;
        end
    end

    // Registered read port so the parser sees a flop output
    always_ff @(posedge clk) begin
        if (rst) begin
            desc_rd_data <= 8'h00;
        end else if (ce) begin
            desc_rd_data <= (desc_rd_addr < 9'(`NCP_DESC_BYTES)) ? desc_ram[desc_rd_addr] : 8'h00;
        end
    end

    // Enumeration: pull-up off while parsing, back on, then report done
    assign enum_done = ce && en_q == ncp_pkg::NCP_EN_CONN && tmr_q == 16'h0000;
    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= ncp_pkg::NCP_EN_IDLE;
            tmr_q <= 16'h0000;
            pullup_en <= 1'b1;
            default_desc <= 1'b0;
        end else if (ce) begin
            case (en_q)
                ncp_pkg::NCP_EN_IDLE: begin
                    if (start_enum) begin
                        en_q <= ncp_pkg::NCP_EN_PARSE;
                        tmr_q <= 16'(PARSE_CYC - 1);
                        pullup_en <= 1'b0;
                        default_desc <= len_q == `NCP_DEFAULT_LEN;
                    end
                end
                ncp_pkg::NCP_EN_PARSE: begin
                    if (tmr_q == 16'h0000) begin
                        en_q <= ncp_pkg::NCP_EN_CONN;
                        tmr_q <= 16'(CONNECT_CYC - 1);
                        pullup_en <= 1'b1;
                    end else begin
                        tmr_q <= tmr_q - 16'h0001;
                    end
                end
                ncp_pkg::NCP_EN_CONN: begin
                    if (tmr_q == 16'h0000) begin
                        en_q <= ncp_pkg::NCP_EN_DONE;
                    end else begin
                        tmr_q <= tmr_q - 16'h0001;
                    end
                end
                ncp_pkg::NCP_EN_DONE: en_q <= ncp_pkg::NCP_EN_DONE;
                default: en_q <= ncp_pkg::NCP_EN_IDLE;
            endcase
        end
    end

    // Read data capture; valid until the master strobes it out
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else if (ce) begin
            if (take && shared_data_bus_in[`NCP_ADDR_BIT]) begin
                // Only a new address drops an open read; stray data leaves it alone
                rd_valid_q <= 1'b0;
            end else if (state_q == ncp_pkg::NCP_RD && !rd_valid_q) begin
                rd_data_q <= reg_view(addr_q);
                rd_valid_q <= 1'b1;
            end else if (rd_take && state_q == ncp_pkg::NCP_RD) begin
                rd_valid_q <= 1'b0;
            end
        end
    end

    // Sticky normal interrupts; a new event beats the clear by a status read
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= 6'h00;
        end else if (ce) begin
            pend_q <= (status_rd ? 6'h00 : pend_q) | irq_src |
                (6'(enum_done) << `NCP_IRQ_ENUM_BIT);
        end
    end

    // Interrupt line belongs to the read while one is open
    always_ff @(posedge clk) begin
        if (rst) begin
            int_n <= 1'b1;
        end else if (ce) begin
            if (state_q == ncp_pkg::NCP_RD) begin
                int_n <= !rd_valid_q;
            end else begin
                int_n <= pend_q == 6'h00;
            end
        end
    end

    // Low data lines only; driven while enabled and selected
    always_ff @(posedge clk) begin
        if (rst) begin
            shared_data_bus_out <= 8'h00;
            shared_data_bus_oe <= 1'b0;
        end else if (ce) begin
            shared_data_bus_oe <= sel && !output_enable_pin_n;
            shared_data_bus_out <= (state_q == ncp_pkg::NCP_RD) ? rd_data_q : {2'h0, pend_q};
        end
    end

    // Configuration outputs from stored registers
    always_ff @(posedge clk) begin
        if (rst) begin
            full_speed_only <= 1'b0;
            interface_setup <= 8'h00;
        end else if (ce) begin
            full_speed_only <= chirp_q[`NCP_CHIRP_FS_BIT];
            interface_setup <= regs_q[6'h01];
        end
    end
endmodule : ncp_top
`default_nettype wire

// file: tb_ncp_top.sv
// Self-checking bench for the nibble command port.
// Assumes ncp_master model; short enumeration counts of 4 cycles each.
`timescale 1ns/1ps
`default_nettype none
module tb_ncp_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [2:0] sel;
    logic cs_n, rd_n, wr_n, oe_n, data_oe, ready, int_n;
    logic pullup_en, full_speed_only, default_desc;
    logic [7:0] din, dout, interface_setup, desc_rd_data;
    logic [8:0] desc_rd_addr = 9'h000;
    logic ce = 1'h1;
    logic [5:0] irq_src = 6'h00;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    // 25 MHz clock and run ceiling
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    ncp_top #(.PARSE_CYC(4), .CONNECT_CYC(4)) ncp_top_inst (
        .clk(clk), .rst(rst), .ce(ce), .endpoint_select_lines(sel), .cs_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .output_enable_pin_n(oe_n),
        .shared_data_bus_in(din), .shared_data_bus_out(dout), .shared_data_bus_oe(data_oe),
        .ready(ready), .int_n(int_n), .irq_src(irq_src), .pullup_en(pullup_en),
        .full_speed_only(full_speed_only), .default_desc(default_desc),
        .interface_setup(interface_setup), .desc_rd_addr(desc_rd_addr),
        .desc_rd_data(desc_rd_data));
    ncp_master ncp_master_inst (.clk(clk), .ready(ready), .int_n(int_n), .rd_data(dout),
        .rd_oe(data_oe),
        .sel_lines(sel), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .oe_n(oe_n), .data(din));
    // Comparisons, one per kind of result
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask : cmp1
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle
    // Write then read back, with stray data while the read is open
    task automatic t_write_read();
        logic [7:0] v;
        ncp_master_inst.wr(6'h01, 8'hB0);
        settle();
        cmp8(interface_setup, 8'hB0);
        ncp_master_inst.send(8'hC1);
        ncp_master_inst.pair(8'hFF);
        ncp_master_inst.fetch(v);
        cmp8(v, 8'hB0);
        cmp8(interface_setup, 8'hB0);
        $display("test write_read done");
    endtask : t_write_read
    // New address drops a half byte; further pairs write again
    task automatic t_drop_multi();
        ncp_master_inst.send(8'h81);
        ncp_master_inst.send(8'h0F);
        ncp_master_inst.send(8'h81);
        ncp_master_inst.send(8'h72);
        ncp_master_inst.send(8'h05);
        settle();
        cmp8(interface_setup, 8'h25);
        ncp_master_inst.pair(8'hA3);
        settle();
        cmp8(interface_setup, 8'hA3);
        $display("test drop_multi done");
    endtask : t_drop_multi
    // Other select codes, chip select high or ce low leave the port deaf
    task automatic t_select();
        for (int i = 0; i < 9; i++) begin
            if (i != 4) begin
                ncp_master_inst.set_sel((i == 8) ? 3'h4 : i[2:0], i == 8);
                ncp_master_inst.wr(6'h01, 8'h11);
            end
        end
        ncp_master_inst.set_sel(3'h4, 1'h0);
        ce <= 1'h0;
        ncp_master_inst.wr(6'h01, 8'h11);
        ce <= 1'h1;
        settle();
        cmp8(interface_setup, 8'hA3);
        $display("test select done");
    endtask : t_select
    // Full-speed-only through the unindexed window, then read back
    task automatic t_chirp();
        logic [7:0] v;
        ncp_master_inst.wr(6'h3A, 8'hFB);
        ncp_master_inst.wr(6'h3B, 8'hE6);
        ncp_master_inst.wr(6'h3C, 8'h02);
        settle();
        cmp1(full_speed_only, 1'h1);
        ncp_master_inst.send(8'hFC);
        ncp_master_inst.fetch(v);
        cmp8(v, 8'h02);
        $display("test chirp done");
    endtask : t_chirp
    // Length six load, store contents, enumeration and its interrupt
    task automatic t_desc();
        logic [7:0] v;
        ncp_master_inst.send(8'hB0);
        ncp_master_inst.pair(8'h06);
        ncp_master_inst.pair(8'h00);
        for (int i = 0; i < 6; i++) begin
            ncp_master_inst.pair(8'h5A + i[7:0]);
        end
        desc_rd_addr <= 9'h002;
        settle();
        cmp1(default_desc, 1'h1);
        cmp8(desc_rd_data, 8'h5C);
        ncp_master_inst.fetch(v);
        cmp8(v, 8'h20);
        cmp1(pullup_en, 1'h1);
        $display("test desc done");
    endtask : t_desc
    // Normal interrupt held while a read is open, then seen in the status byte
    task automatic t_held_irq();
        logic [7:0] v;
        ncp_master_inst.send(8'hC1);
        irq_src <= 6'h05;
        @(posedge clk);
        irq_src <= 6'h00;
        ncp_master_inst.fetch(v);
        cmp8(v, 8'hA3);
        ncp_master_inst.fetch(v);
        cmp8(v, 8'h05);
        cmp1(int_n, 1'h1);
        $display("test held_irq done");
    endtask : t_held_irq
    // Counts and verdict; the only place the run ends
    task automatic tally_and_finish();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    // Reset for 4 cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        t_write_read();
        t_drop_multi();
        t_select();
        t_chirp();
        t_desc();
        t_held_irq();
        tally_and_finish();
    end
endmodule : tb_ncp_top
`default_nettype wire
